// ---- hdl/vpic_pkg.sv ----
// Constants for the vectored priority interrupt controller
package vpic_pkg;
  localparam int NSRC  = 24;
  localparam int NEXC  = 8;
  localparam int IDXW  = 5;
  localparam int LVLW  = 2;
  localparam int VECW  = 24;
  localparam int AW    = 8;
  // Vector addresses
  localparam logic [VECW-1:0] VEC_RESET = 24'h000004;
  localparam logic [VECW-1:0] VEC_EXC   = 24'h000008;
  localparam logic [VECW-1:0] VEC_RSVD  = 24'h00000C;
  localparam logic [VECW-1:0] VEC_FIRST = 24'h000010;
  localparam logic [VECW-1:0] VEC_LAST  = 24'h00006C;
  localparam int              VEC_STEP_SH = 2;
  // Source indices in fixed order
  localparam int SRC_PORT7 = 8;
  localparam int SRC_PORT0 = 15;
  localparam int SRC_PWM   = 16;
  localparam int SRC_PC3   = 20;
  localparam int SRC_PC0   = 23;
  localparam int NPORT     = 8;
  localparam int NPC       = 4;
  localparam int NPERIPH   = 12;
  localparam int NPERIPH_LO = 8;
  localparam int EXC_ILL   = 3;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_REQ   = 8'h00;
  localparam logic [AW-1:0] OFS_SET   = 8'h04;
  localparam logic [AW-1:0] OFS_LVLA  = 8'h08;
  localparam logic [AW-1:0] OFS_LVLB  = 8'h0C;
  localparam logic [AW-1:0] OFS_FLAG  = 8'h10;
  localparam logic [AW-1:0] OFS_MUX   = 8'h14;
  localparam logic [AW-1:0] OFS_EDGE  = 8'h18;
  localparam logic [AW-1:0] OFS_EXC   = 8'h1C;
  localparam logic [AW-1:0] OFS_STAT  = 8'h20;
  // Field positions
  localparam int FLAG_GIE    = 0;
  localparam int MUX_DBG     = 0;
  localparam int MUX_COMP    = 7;
  localparam int MUX_PC_LSB  = 8;
  localparam int MUX_AD_LSB  = 16;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_REQ    = 16;
  localparam int LVL_PER_REG = 16;
  // Reset values and AXI response codes
  localparam logic [NSRC*LVLW-1:0] LVL_RST = '0;
  localparam logic [NPORT-1:0]     EDGE_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/vpic_edge.sv ----
// Pin synchroniser with selectable rising and falling edge pulses
module vpic_edge #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  output logic      [W-1:0] pulse
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  initial begin
    if (W < 1) $error("vpic_edge: W must be at least 1");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // One-cycle pulse per selected edge
  assign pulse = (sync_q & ~prev_q & rise_en) | (~sync_q & prev_q & fall_en);
endmodule

// ---- hdl/vpic_top.sv ----
// Vectored priority interrupt controller with AXI4-Lite registers
module vpic_top #(
  parameter int NUM_EXC = vpic_pkg::NEXC
) (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic [vpic_pkg::AW-1:0]   S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [vpic_pkg::AW-1:0]   S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  input  wire logic [vpic_pkg::NPERIPH-1:0] PERIPH_IRQ,
  input  wire logic                      DBG_IRQ,
  input  wire logic [vpic_pkg::NPC-1:0]  DMA_IRQ,
  input  wire logic [vpic_pkg::NPORT-1:0] PORTA_PIN,
  input  wire logic [vpic_pkg::NPORT-1:0] PORTD_PIN,
  input  wire logic [vpic_pkg::NPC-1:0]  PORTC_PIN,
  input  wire logic                      COMP_OUT,
  input  wire logic [NUM_EXC-1:0]        EXC_EVENT,
  input  wire logic                      CPU_ACK,
  input  wire logic                      ENABLE_IRQ_INSTR,
  input  wire logic                      DISABLE_IRQ_INSTR,
  input  wire logic                      TRAP_INSTR,
  input  wire logic                      FLAG_LOAD,
  input  wire logic                      FLAG_LOAD_GIE,
  output logic                           IRQ_REQ,
  output logic [vpic_pkg::VECW-1:0]      VEC_ADDR,
  output logic                           EXC_REQ,
  output logic                           GLOBAL_IRQ_EN
);
  localparam int N = vpic_pkg::NSRC;
  localparam int LW = vpic_pkg::LVLW;

  initial begin
    if (NUM_EXC <= vpic_pkg::EXC_ILL || NUM_EXC > 32) $error("vpic_top: NUM_EXC out of range");
  end

  logic [N-1:0]       req_q;
  logic [N-1:0]       soft_q;
  logic [N*LW-1:0]    lvl_q;
  logic               gie_q;
  logic               comp_sel_q;
  logic               dbg_sel_q;
  logic [vpic_pkg::NPC-1:0]   pc_sel_q;
  logic [vpic_pkg::NPORT-1:0] ad_sel_q;
  logic [vpic_pkg::NPORT-1:0] edge_q;
  logic [NUM_EXC-1:0] exc_q;
  logic [vpic_pkg::IDXW-1:0] win_q;
  logic [LW-1:0]      win_lvl_q;
  logic               aw_full_q;
  logic               w_full_q;
  logic [vpic_pkg::AW-1:0] waddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               wr_en;
  logic [31:0]        wmask;
  logic [N-1:0]       src;
  logic [N-1:0]       act;
  logic [N-1:0]       ack_mask;
  logic [vpic_pkg::IDXW-1:0] win_d;
  logic [LW-1:0]      win_lvl_d;
  logic               win_ok;
  logic [NUM_EXC-1:0] exc_new;
  logic [2*vpic_pkg::NPORT-1:0] ad_edge;
  logic [vpic_pkg::NPORT-1:0] port_edge;
  logic [vpic_pkg::NPC:0]     dual_edge;

  // Level field of one source
  function automatic logic [LW-1:0] lvl_of(input logic [N*LW-1:0] l, input int i);
    lvl_of = l[i*LW +: LW];
  endfunction

  // Masked update of a register word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
    wmerge = (old & ~m) | (d & m);
  endfunction

  // Pin edge capture, both ports synchronised before the select
  vpic_edge #(.W(2 * vpic_pkg::NPORT)) u_port_edge (
    .clk     (CLK),
    .rst     (RST),
    .pin     ({PORTD_PIN, PORTA_PIN}),
    .rise_en ({2{edge_q}}),
    .fall_en ({2{~edge_q}}),
    .pulse   (ad_edge)
  );

  always_comb begin
    for (int k = 0; k < vpic_pkg::NPORT; k++) begin
      port_edge[k] = ad_sel_q[k] ? ad_edge[vpic_pkg::NPORT + k] : ad_edge[k];
    end
  end

  vpic_edge #(.W(vpic_pkg::NPC + 1)) u_dual_edge (
    .clk     (CLK),
    .rst     (RST),
    .pin     ({COMP_OUT, PORTC_PIN}),
    .rise_en ('1),
    .fall_en ('1),
    .pulse   (dual_edge)
  );

  // Source pulses in fixed vector order
  always_comb begin
    src = '0;
    src[vpic_pkg::NPERIPH_LO-1:0] = PERIPH_IRQ[vpic_pkg::NPERIPH_LO-1:0];
    src[vpic_pkg::SRC_PWM +: vpic_pkg::NPC] = PERIPH_IRQ[vpic_pkg::NPERIPH-1:vpic_pkg::NPERIPH_LO];
    for (int k = 0; k < vpic_pkg::NPORT; k++) begin
      src[vpic_pkg::SRC_PORT0 - k] = port_edge[k];
    end
    src[vpic_pkg::SRC_PORT7] = comp_sel_q ? dual_edge[vpic_pkg::NPC] : port_edge[vpic_pkg::NPORT-1];
    src[vpic_pkg::SRC_PORT0] = dbg_sel_q ? DBG_IRQ : port_edge[0];
    for (int k = 0; k < vpic_pkg::NPC; k++) begin
      src[vpic_pkg::SRC_PC0 - k] = pc_sel_q[k] ? dual_edge[k] : DMA_IRQ[k];
    end
  end

  // Winner: highest level, then earliest in order
  always_comb begin
    act = req_q | soft_q;
    win_d = '0;
    win_lvl_d = '0;
    win_ok = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (act[i] && lvl_of(lvl_q, i) != '0 && lvl_of(lvl_q, i) >= win_lvl_d) begin
        win_d = vpic_pkg::IDXW'(i);
        win_lvl_d = lvl_of(lvl_q, i);
        win_ok = 1'b1;
      end
    end
  end

  always_comb begin
    ack_mask = '0;
    if (CPU_ACK) begin
      ack_mask[win_q] = 1'b1;
    end
  end

  assign exc_new = EXC_EVENT & ~exc_q;
  assign wr_en = aw_full_q && w_full_q && !S_AXI_BVALID;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
  end

  // Pending and software-set requests
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      req_q <= '0;
    end else begin
      req_q <= (req_q
               & ~ack_mask
               & ~((wr_en && waddr_q == vpic_pkg::OFS_REQ) ? wdata_q[N-1:0] & wmask[N-1:0] : '0))
               | src
               | ((wr_en && waddr_q == vpic_pkg::OFS_SET) ? wdata_q[N-1:0] & wmask[N-1:0] : '0);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      soft_q <= '0;
    end else begin
      soft_q <= (soft_q & ~ack_mask & ~((wr_en && waddr_q == vpic_pkg::OFS_REQ) ? wdata_q[N-1:0] & wmask[N-1:0] : '0))
                | ((wr_en && waddr_q == vpic_pkg::OFS_SET) ? wdata_q[N-1:0] & wmask[N-1:0] : '0);
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lvl_q      <= vpic_pkg::LVL_RST;
      comp_sel_q <= 1'b0;
      dbg_sel_q  <= 1'b0;
      pc_sel_q   <= '0;
      ad_sel_q   <= '0;
      edge_q     <= vpic_pkg::EDGE_RST;
    end else if (wr_en) begin
      unique case (waddr_q)
        vpic_pkg::OFS_LVLA: begin
          lvl_q[0 +: 32] <= wmerge(lvl_q[0 +: 32], wdata_q, wmask);
        end
        vpic_pkg::OFS_LVLB: begin
          lvl_q[N*LW-1:32] <= 16'(wmerge({16'h0000, lvl_q[N*LW-1:32]}, wdata_q, wmask));
        end
        vpic_pkg::OFS_MUX: begin
          if (wstrb_q[0]) begin
            comp_sel_q <= wdata_q[vpic_pkg::MUX_COMP];
            dbg_sel_q  <= wdata_q[vpic_pkg::MUX_DBG];
          end
          if (wstrb_q[1]) pc_sel_q <= wdata_q[vpic_pkg::MUX_PC_LSB +: vpic_pkg::NPC];
          if (wstrb_q[2]) ad_sel_q <= wdata_q[vpic_pkg::MUX_AD_LSB +: vpic_pkg::NPORT];
        end
        vpic_pkg::OFS_EDGE: begin
          if (wstrb_q[0]) edge_q <= wdata_q[vpic_pkg::NPORT-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Exception status bits, write 1 to clear, new event wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      exc_q <= '0;
    end else begin
      exc_q <= (exc_q & ~((wr_en && waddr_q == vpic_pkg::OFS_EXC) ? wdata_q[NUM_EXC-1:0] & wmask[NUM_EXC-1:0] : '0))
               | EXC_EVENT;
    end
  end

  // Global interrupt enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gie_q <= 1'b0;
    end else if (|exc_new || TRAP_INSTR || DISABLE_IRQ_INSTR || CPU_ACK) begin
      gie_q <= 1'b0;
    end else if (ENABLE_IRQ_INSTR) begin
      gie_q <= 1'b1;
    end else if (FLAG_LOAD) begin
      gie_q <= FLAG_LOAD_GIE;
    end else if (wr_en && waddr_q == vpic_pkg::OFS_FLAG && wstrb_q[0]) begin
      gie_q <= wdata_q[vpic_pkg::FLAG_GIE];
    end
  end

  // Request and vector presented to the core
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ_REQ   <= 1'b0;
      EXC_REQ   <= 1'b0;
      VEC_ADDR  <= vpic_pkg::VEC_RESET;
      win_q     <= '0;
      win_lvl_q <= '0;
    end else begin
      EXC_REQ   <= |exc_new;
      IRQ_REQ   <= win_ok && gie_q && !CPU_ACK && ~|exc_new;
      win_q     <= win_d;
      win_lvl_q <= win_lvl_d;
      if (|exc_new) begin
        VEC_ADDR <= vpic_pkg::VEC_EXC;
      end else if (win_ok) begin
        VEC_ADDR <= vpic_pkg::VEC_FIRST + (vpic_pkg::VECW'(win_d) << vpic_pkg::VEC_STEP_SH);
      end
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      aw_full_q     <= 1'b0;
      waddr_q       <= '0;
    end else begin
      S_AXI_AWREADY <= S_AXI_AWVALID && !S_AXI_AWREADY && !aw_full_q && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        waddr_q   <= {S_AXI_AWADDR[vpic_pkg::AW-1:2], 2'b00};
      end else if (wr_en) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_WREADY <= 1'b0;
      w_full_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end else begin
      S_AXI_WREADY <= S_AXI_WVALID && !S_AXI_WREADY && !w_full_q && !S_AXI_BVALID;
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end else if (wr_en) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= vpic_pkg::RESP_OKAY;
    end else if (wr_en) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (waddr_q > vpic_pkg::OFS_EXC) ? vpic_pkg::RESP_SLVERR : vpic_pkg::RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= vpic_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= vpic_pkg::RESP_OKAY;
        S_AXI_RDATA  <= '0;
        unique case ({S_AXI_ARADDR[vpic_pkg::AW-1:2], 2'b00})
          vpic_pkg::OFS_REQ:  S_AXI_RDATA[N-1:0] <= req_q | soft_q;
          vpic_pkg::OFS_SET:  S_AXI_RDATA[N-1:0] <= soft_q;
          vpic_pkg::OFS_LVLA: S_AXI_RDATA <= lvl_q[0 +: 32];
          vpic_pkg::OFS_LVLB: S_AXI_RDATA[15:0] <= lvl_q[N*LW-1:32];
          vpic_pkg::OFS_FLAG: S_AXI_RDATA[vpic_pkg::FLAG_GIE] <= gie_q;
          vpic_pkg::OFS_MUX: begin
            S_AXI_RDATA[vpic_pkg::MUX_COMP] <= comp_sel_q;
            S_AXI_RDATA[vpic_pkg::MUX_DBG]  <= dbg_sel_q;
            S_AXI_RDATA[vpic_pkg::MUX_PC_LSB +: vpic_pkg::NPC]  <= pc_sel_q;
            S_AXI_RDATA[vpic_pkg::MUX_AD_LSB +: vpic_pkg::NPORT] <= ad_sel_q;
          end
          vpic_pkg::OFS_EDGE: S_AXI_RDATA[vpic_pkg::NPORT-1:0] <= edge_q;
          vpic_pkg::OFS_EXC:  S_AXI_RDATA[NUM_EXC-1:0] <= exc_q;
          vpic_pkg::OFS_STAT: begin
            S_AXI_RDATA[vpic_pkg::IDXW-1:0] <= win_q;
            S_AXI_RDATA[vpic_pkg::STAT_LVL_LSB +: LW] <= win_lvl_q;
            S_AXI_RDATA[vpic_pkg::STAT_REQ] <= IRQ_REQ;
          end
          default: S_AXI_RRESP <= vpic_pkg::RESP_SLVERR;
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  assign GLOBAL_IRQ_EN = gie_q;
endmodule

// ---- tb/vpic_top_sva.sv ----
// Checker on the ports of the interrupt controller
module vpic_top_sva #(
  parameter int NUM_EXC = vpic_pkg::NEXC
) (
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic [NUM_EXC-1:0] EXC_EVENT,
  input wire logic               ENABLE_IRQ_INSTR,
  input wire logic               DISABLE_IRQ_INSTR,
  input wire logic               TRAP_INSTR,
  input wire logic               FLAG_LOAD,
  input wire logic               FLAG_LOAD_GIE,
  input wire logic               CPU_ACK,
  input wire logic               S_AXI_BVALID,
  input wire logic               S_AXI_RVALID,
  input wire logic [1:0]         S_AXI_RRESP,
  input wire logic               IRQ_REQ,
  input wire logic [23:0]        VEC_ADDR,
  input wire logic               EXC_REQ,
  input wire logic               GLOBAL_IRQ_EN
);
  logic clr;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  assign clr = DISABLE_IRQ_INSTR || TRAP_INSTR || CPU_ACK || (|EXC_EVENT);
  AST_EXC_VEC: assert property (EXC_REQ |-> VEC_ADDR == vpic_pkg::VEC_EXC && !IRQ_REQ && !GLOBAL_IRQ_EN)
    else $error("exception not vectored alone");
  AST_EXC_CAUSE: assert property (EXC_REQ |-> $past(|EXC_EVENT))
    else $error("exception request without event");
  AST_IRQ_GIE: assert property (IRQ_REQ |-> GLOBAL_IRQ_EN || $past(GLOBAL_IRQ_EN))
    else $error("request offered while disabled");
  AST_VEC_RANGE: assert property (IRQ_REQ |-> VEC_ADDR >= 24'h10 && VEC_ADDR <= 24'h6C && VEC_ADDR[1:0] == 2'h0)
    else $error("vector out of table");
  AST_ACK_CLR: assert property (CPU_ACK && IRQ_REQ |=> !IRQ_REQ && !GLOBAL_IRQ_EN)
    else $error("acknowledge did not clear");
  AST_ENABLE_SET: assert property (ENABLE_IRQ_INSTR && !clr |=> GLOBAL_IRQ_EN)
    else $error("enable instruction ignored");
  AST_DISABLE_CLR: assert property (DISABLE_IRQ_INSTR || TRAP_INSTR |=> !GLOBAL_IRQ_EN)
    else $error("disable or trap ignored");
  AST_FLAG_LOAD: assert property (FLAG_LOAD && !ENABLE_IRQ_INSTR && !clr |=>
    GLOBAL_IRQ_EN == $past(FLAG_LOAD_GIE))
    else $error("flag load not restored");
  AST_GIE_RISE: assert property ($rose(GLOBAL_IRQ_EN) |->
    $past(ENABLE_IRQ_INSTR) || $past(FLAG_LOAD) || S_AXI_BVALID)
    else $error("enable rose without cause");
  cover property (EXC_REQ);
  cover property (CPU_ACK && IRQ_REQ);
  cover property (S_AXI_RVALID && S_AXI_RRESP == vpic_pkg::RESP_SLVERR);
endmodule
bind vpic_top vpic_top_sva #(.NUM_EXC(NUM_EXC)) vpic_top_sva_i (
  .CLK(CLK), .RST(RST), .EXC_EVENT(EXC_EVENT), .ENABLE_IRQ_INSTR(ENABLE_IRQ_INSTR),
  .DISABLE_IRQ_INSTR(DISABLE_IRQ_INSTR), .TRAP_INSTR(TRAP_INSTR), .FLAG_LOAD(FLAG_LOAD),
  .FLAG_LOAD_GIE(FLAG_LOAD_GIE), .CPU_ACK(CPU_ACK), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RRESP(S_AXI_RRESP), .IRQ_REQ(IRQ_REQ), .VEC_ADDR(VEC_ADDR), .EXC_REQ(EXC_REQ), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN)
);

// ---- tb/vpic_cpu_model.sv ----
// Core model that acknowledges offered requests and fetches vector entries
module vpic_cpu_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ack_en,
  input  wire logic [3:0]  dly,
  input  wire logic        irq_req,
  input  wire logic [23:0] vec_addr,
  output logic             cpu_ack,
  output logic [23:0]      vec_seen,
  output logic [23:0]      target,
  output int               ack_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  // Table byte contents are arbitrary
  function automatic logic [7:0] tbyte(input logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
      ack_cnt <= 0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      if (irq_req) begin
        vec_seen <= vec_addr;
        target   <= {tbyte(vec_addr + 24'h1), tbyte(vec_addr + 24'h2), tbyte(vec_addr + 24'h3)};
        ack_cnt  <= ack_cnt + 1;
      end
    end else if (irq_req && ack_en) begin
      if (wait_q == dly) begin
        cpu_ack <= 1'b1;
        wait_q  <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule

// ---- tb/vpic_tb_top.sv ----
// Testbench of the interrupt controller
module vpic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, DBG_IRQ, COMP_OUT;
  logic        CPU_ACK, ENABLE_IRQ_INSTR, DISABLE_IRQ_INSTR, TRAP_INSTR, FLAG_LOAD, FLAG_LOAD_GIE, IRQ_REQ, EXC_REQ;
  logic        GLOBAL_IRQ_EN, ack_en;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [3:0]  S_AXI_WSTRB, DMA_IRQ, PORTC_PIN, dly;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, PORTA_PIN, PORTD_PIN, EXC_EVENT;
  logic [11:0] PERIPH_IRQ;
  logic [23:0] VEC_ADDR, vec_seen;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  int          fails = 0, total_checks = 0, exc_n = 0, cyc = 0, ack_cnt;
  localparam logic [5:0] GT [6] = '{6'h28, 6'h04, 6'h31, 6'h02, 6'h28, 6'h01};

  vpic_top vpic_top_i (.CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PERIPH_IRQ, .DBG_IRQ, .DMA_IRQ,
    .PORTA_PIN, .PORTD_PIN, .PORTC_PIN, .COMP_OUT, .EXC_EVENT, .CPU_ACK, .ENABLE_IRQ_INSTR, .DISABLE_IRQ_INSTR,
    .TRAP_INSTR, .FLAG_LOAD, .FLAG_LOAD_GIE, .IRQ_REQ, .VEC_ADDR, .EXC_REQ, .GLOBAL_IRQ_EN);
  vpic_cpu_model vpic_cpu_model_i (.clk(CLK), .rst(RST), .ack_en(ack_en), .dly(dly), .irq_req(IRQ_REQ),
    .vec_addr(VEC_ADDR), .cpu_ack(CPU_ACK), .vec_seen(vec_seen), .target(), .ack_cnt(ack_cnt));

  always #20 CLK = ~CLK;
  always @(posedge CLK) if (EXC_REQ === 1'b1) exc_n <= exc_n + 1;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = vpic_pkg::RESP_OKAY);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk(S_AXI_BRESP, er);
    @(posedge CLK);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = vpic_pkg::RESP_OKAY);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, e);
    chk(S_AXI_RRESP, er);
    @(posedge CLK);
  endtask

  // One-cycle pulse on {enable, disable, trap, flag load}
  task automatic pls(input logic [3:0] v);
    {ENABLE_IRQ_INSTR, DISABLE_IRQ_INSTR, TRAP_INSTR, FLAG_LOAD} <= v;
    @(posedge CLK);
    {ENABLE_IRQ_INSTR, DISABLE_IRQ_INSTR, TRAP_INSTR, FLAG_LOAD} <= 4'h0;
    @(posedge CLK);
  endtask

  // One-cycle pulse on {EXC_EVENT, DMA_IRQ, DBG_IRQ, PERIPH_IRQ}
  task automatic pin(input logic [31:0] v);
    {EXC_EVENT, DMA_IRQ, DBG_IRQ, PERIPH_IRQ} <= v[24:0];
    @(posedge CLK);
    {EXC_EVENT, DMA_IRQ, DBG_IRQ, PERIPH_IRQ} <= 25'h0;
    @(posedge CLK);
  endtask

  task automatic serve(input logic [23:0] e);
    int n;
    n = ack_cnt;
    pls(4'h8);
    while (ack_cnt == n) @(posedge CLK);
    chk(vec_seen, e);
  endtask

  task automatic exc(input int b, input int inc);
    int n;
    n = exc_n;
    pin(32'h1 << (17 + b));
    repeat (2) @(posedge CLK);
    chk(exc_n - n, inc);
  endtask

  initial begin
    {CLK, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, COMP_OUT} = '0;
    {ENABLE_IRQ_INSTR, DISABLE_IRQ_INSTR, TRAP_INSTR, FLAG_LOAD, FLAG_LOAD_GIE} = '0;
    {EXC_EVENT, DMA_IRQ, DBG_IRQ, PERIPH_IRQ} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, PORTD_PIN, PORTC_PIN, dly} = '0;
    {RST, ack_en, PORTA_PIN, S_AXI_WSTRB} = '1;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk(VEC_ADDR, vpic_pkg::VEC_RESET);
    chk(GLOBAL_IRQ_EN, 1'b0);
    axr(vpic_pkg::OFS_FLAG, 32'h0);
    axr(8'h24, 32'h0, vpic_pkg::RESP_SLVERR);
    axw(8'h24, 32'h1, vpic_pkg::RESP_SLVERR);
    axw(vpic_pkg::OFS_REQ, 32'h00FFFFFF);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      FLAG_LOAD_GIE <= GT[i][4];
      pls(GT[i][3:0]);
      chk(GLOBAL_IRQ_EN, GT[i][5]);
    end
    axw(vpic_pkg::OFS_FLAG, 32'h1);
    axr(vpic_pkg::OFS_FLAG, 32'h1);
    axw(vpic_pkg::OFS_FLAG, 32'h0);
    chk(GLOBAL_IRQ_EN, 1'b0);
    $display("enable test done");
    axw(vpic_pkg::OFS_LVLA, 32'h55555555);
    axw(vpic_pkg::OFS_LVLB, 32'h00005555);
    for (int i = 0; i < 24; i++) begin
      axw(vpic_pkg::OFS_SET, 32'h1 << i);
      axr(vpic_pkg::OFS_SET, 32'h1 << i);
      chk(IRQ_REQ, 1'b0);
      serve(24'(16 + 4 * i));
      axr(vpic_pkg::OFS_REQ, 32'h0);
    end
    $display("order test done");
    dly <= 4'h5;
    axw(vpic_pkg::OFS_SET, 32'h00000220);
    serve(24'h24);
    serve(24'h34);
    axw(vpic_pkg::OFS_LVLA, 32'h55565555);
    axw(vpic_pkg::OFS_LVLB, 32'h0000D555);
    axw(vpic_pkg::OFS_SET, 32'h00800101);
    serve(24'h6C);
    serve(24'h30);
    serve(24'h10);
    dly <= 4'h0;
    $display("level test done");
    pin(32'h1 << 11);
    axr(vpic_pkg::OFS_REQ, 32'h1 << 19);
    axw(vpic_pkg::OFS_REQ, 32'h1 << 19);
    axr(vpic_pkg::OFS_REQ, 32'h0);
    pin(32'h1 << 13);
    serve(24'h6C);
    axw(vpic_pkg::OFS_MUX, 32'h1);
    axw(vpic_pkg::OFS_REQ, 32'h00FFFFFF);
    pin(32'h1 << 12);
    serve(24'h4C);
    axw(vpic_pkg::OFS_MUX, 32'h81);
    axw(vpic_pkg::OFS_REQ, 32'h00FFFFFF);
    COMP_OUT <= 1'b1;
    serve(24'h30);
    COMP_OUT <= 1'b0;
    serve(24'h30);
    axw(vpic_pkg::OFS_MUX, 32'h0);
    axw(vpic_pkg::OFS_REQ, 32'h00FFFFFF);
    PORTA_PIN[1] <= 1'b0;
    serve(24'h48);
    PORTA_PIN[1] <= 1'b1;
    repeat (6) @(posedge CLK);
    axr(vpic_pkg::OFS_REQ, 32'h0);
    axw(vpic_pkg::OFS_EDGE, 32'h2);
    PORTA_PIN[1] <= 1'b0;
    repeat (6) @(posedge CLK);
    axr(vpic_pkg::OFS_REQ, 32'h0);
    PORTA_PIN[1] <= 1'b1;
    serve(24'h48);
    axw(vpic_pkg::OFS_MUX, 32'h00020100);
    PORTC_PIN[0] <= 1'b1;
    serve(24'h6C);
    PORTD_PIN[1] <= 1'b1;
    serve(24'h48);
    $display("source select test done");
    ack_en <= 1'b0;
    axw(vpic_pkg::OFS_SET, 32'h1);
    pls(4'h8);
    repeat (3) @(posedge CLK);
    chk(IRQ_REQ, 1'b1);
    axr(vpic_pkg::OFS_STAT, 32'h00010100);
    exc(2, 1);
    chk(GLOBAL_IRQ_EN, 1'b0);
    chk(IRQ_REQ, 1'b0);
    axr(vpic_pkg::OFS_EXC, 32'h4);
    exc(2, 0);
    exc(3, 1);
    exc(3, 0);
    axr(vpic_pkg::OFS_EXC, 32'hC);
    axw(vpic_pkg::OFS_EXC, 32'h4);
    axr(vpic_pkg::OFS_EXC, 32'h8);
    exc(2, 1);
    axw(vpic_pkg::OFS_EXC, 32'hFF);
    ack_en <= 1'b1;
    serve(24'h10);
    pls(4'h8);
    chk(GLOBAL_IRQ_EN, 1'b1);
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk(GLOBAL_IRQ_EN, 1'b0);
    chk(VEC_ADDR, vpic_pkg::VEC_RESET);
    $display("exception test done");
    give_verdict();
  end
endmodule
